// File: pkg/pad_lp_pkg.sv
package pad_lp_pkg;
  localparam int NUM_PADS = 34;
  localparam int NUM_LP_PINS = 18;
  localparam int DRV_W = 2;
  localparam int PAD_IDX_W = 6;
  localparam int SIG_IDX_W = 8;
  // Held bundle: out, oe, drive, pull-up, pull-down
  localparam int HOLD_W = 4 + DRV_W;
  localparam logic ROUTE_MAIN_RESET = 1'b1;
  localparam logic VSEL_1V8 = 1'b1;
  localparam logic VSEL_LP_DOMAIN = 1'b0;
  localparam logic HOLD_RESET = 1'b0;
  // Low-power pin number to pad number, low-power pin 0 rightmost
  localparam logic [NUM_LP_PINS-1:0][PAD_IDX_W-1:0] LP_PAD_MAP = {
    6'h11, 6'h10, 6'h0F, 6'h0E, 6'h0D, 6'h0C, 6'h0B, 6'h0A, 6'h09,
    6'h08, 6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};
  typedef enum logic [1:0]
  {
    STRAP_WAIT = 2'b00,
    STRAP_DONE = 2'b01
  } strap_state_t;
endpackage

// File: rtl/pad_hold_cell.sv
`timescale 1ns/1ns
module pad_hold_cell
  import pad_lp_pkg::*;
#(
  parameter int W = HOLD_W
)
(
  input wire logic clk,
  input wire logic npor,
  input wire logic holdEn,
  input wire logic [W-1:0] live,
  output logic [W-1:0] out,
  output logic held
);
  logic [W-1:0] saved;
  logic [W-1:0] next_saved;
  logic next_held;

  // Only power-on reset clears it, so core and system resets pass through
  always_comb
  begin
    next_saved = saved;
    next_held = holdEn;
    if (holdEn && !held)
    begin
      next_saved = live; // see R16
    end
  end

  always_ff @(posedge clk)
  begin
    if (!npor)
    begin
      saved <= '0;
      held <= HOLD_RESET;
    end
    else
    begin
      saved <= next_saved;
      held <= next_held; // see R10
    end
  end

  // First hold cycle passes live state, which is exactly what gets captured
  assign out = held ? saved : live; // see R9

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!npor);

  a_hold_capture: assert property ($rose(holdEn) |=> out == $past(live)) // see R16
    else $error("Hold did not capture the pad state");
  a_hold_freeze: assert property (held && holdEn |=> $stable(out)) // see R9
    else $error("Held pad state changed");
  a_hold_release: assert property ($fell(holdEn) |=> out == live) // see R16
    else $error("Released pad does not follow live state");
endmodule

// File: rtl/sig_index_info.sv
`timescale 1ns/1ns
module sig_index_info
  import pad_lp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [SIG_IDX_W-1:0] sigIndex,
  output logic sigHasInput,
  output logic sigHasOutput,
  output logic sigDirectBypass
);
  logic next_in;
  logic next_out;
  logic next_direct;

  // Gaps in the numbering answer with no input and no output
  always_comb
  begin
    next_in = sigIndex inside {[8'h00:8'h12], [8'h17:8'h24], [8'h27:8'h3A],
      [8'h3D:8'h5A], [8'h5F:8'h7C], [8'h8C:8'h9B], [8'hA4:8'hB5],
      [8'hBE:8'hC3], [8'hC6:8'hCE]}; // see R13
    next_out = sigIndex inside {[8'h00:8'h12], [8'h17:8'h25], [8'h3D:8'h79],
      [8'h8C:8'hB6], [8'hE0:8'hE4]}; // see R13
    next_direct = sigIndex inside {[8'h00:8'h05], [8'h08:8'h0F],
      [8'h11:8'h12], [8'h3F:8'h44]}; // see R13
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sigHasInput <= 1'b0;
      sigHasOutput <= 1'b0;
      sigDirectBypass <= 1'b0;
    end
    else
    begin
      sigHasInput <= next_in;
      sigHasOutput <= next_out;
      sigDirectBypass <= next_direct;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_bypass_both_ways: assert property (sigDirectBypass |-> sigHasInput && sigHasOutput) // see R13
    else $error("Bypass index lacks a peripheral input or output");
endmodule

// File: rtl/pad_lowpower_route_hold.sv
`timescale 1ns/1ns
// Functional notes
// R1: Each low-power pin has a route-to-main-mux bit, reset to 1.
// R2: Cleared route bit connects pad input and output to low-power subsystem.
// R3: Low-power routed pad follows its pin control fields; analog enabled.
// R4: Low-power pin numbering maps to pad numbering through a fixed table.
// R5: Sleep-set select high during light sleep picks the sleep control set.
// R6: Sleep drive, pulls and output enable replace normal fields and matrix enable.
// R7: Sleep-set select low or normal execution keeps the normal fields.
// R8: Every pad has its own hold enable in a low-power domain register.
// R9: Held pad keeps captured state whatever internal or routing changes occur.
// R10: Hold state survives core and system resets.
// R11: Strap sampled at reset: high gives 1.8V, low the low-power supply level.
// R12: Fuse sets default supply choice; software override wins afterwards.
// R13: Signal index names at most one input and output; some allow bypass.
// R14: Low-power pads keep output in deep sleep and may wake the device.
// R15: Light-sleep status input switches control sets combinationally per pad.
// R16: Hold captures out, enable, drive and pulls on rise; clear releases.
module pad_lowpower_route_hold
  import pad_lp_pkg::*;
#(
  parameter int NPADS = NUM_PADS,
  parameter int NLP = NUM_LP_PINS
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic npor,
  input wire logic routeWrEn,
  input wire logic [NLP-1:0] routeWrData,
  output logic [NLP-1:0] padRouteToMainMux,
  input wire logic [NPADS-1:0] muxOut,
  input wire logic [NPADS-1:0] matrixOutputEnableSel,
  input wire logic [NPADS-1:0][DRV_W-1:0] normalDriveStrength,
  input wire logic [NPADS-1:0] normalPullUp,
  input wire logic [NPADS-1:0] normalPullDown,
  input wire logic [NPADS-1:0] sleepSetSelect,
  input wire logic [NPADS-1:0][DRV_W-1:0] sleepDriveStrength,
  input wire logic [NPADS-1:0] sleepPullUp,
  input wire logic [NPADS-1:0] sleepPullDown,
  input wire logic [NPADS-1:0] sleepOutputEnable,
  output logic [NPADS-1:0] mainIn,
  input wire logic [NLP-1:0] lpOut,
  input wire logic [NLP-1:0] lpOe,
  input wire logic [NLP-1:0][DRV_W-1:0] lpDrive,
  input wire logic [NLP-1:0] lpPullUp,
  input wire logic [NLP-1:0] lpPullDown,
  input wire logic [NLP-1:0] lpWakeEn,
  output logic [NLP-1:0] lpIn,
  output logic [NLP-1:0] lpAnalogEn,
  output logic [NLP-1:0] lpWakeReq,
  input wire logic lightSleep,
  input wire logic deepSleep,
  input wire logic holdWrEn,
  input wire logic [NPADS-1:0] holdWrData,
  output logic [NPADS-1:0] holdEnable,
  input wire logic [NPADS-1:0] padIn,
  output logic [NPADS-1:0] padOut,
  output logic [NPADS-1:0] padOe,
  output logic [NPADS-1:0][DRV_W-1:0] padDrive,
  output logic [NPADS-1:0] padPullUp,
  output logic [NPADS-1:0] padPullDown,
  output logic [NPADS-1:0] padHeld,
  input wire logic voltageStrapPad,
  input wire logic fuseVoltForce,
  input wire logic fuseVoltSel1v8,
  input wire logic swVoltOverride,
  input wire logic swVoltSel1v8,
  output logic sdioVolt1v8,
  input wire logic [SIG_IDX_W-1:0] sigIndex,
  output logic sigHasInput,
  output logic sigHasOutput,
  output logic sigDirectBypass
);
  logic [NLP-1:0] next_route;
  logic [NLP-1:0] keepOut;
  logic [NLP-1:0] keepOe;
  logic [NLP-1:0] next_keepOut;
  logic [NLP-1:0] next_keepOe;
  logic [NLP-1:0] next_wake;
  logic [NLP-1:0] lpOutEff;
  logic [NLP-1:0] lpOeEff;
  strap_state_t strapState;
  strap_state_t next_strapState;
  logic strapSel;
  logic next_strapSel;
  logic next_volt;
  logic [NPADS-1:0] next_hold;
  logic [NPADS-1:0] lpRouted;
  logic [NPADS-1:0] useSleep;
  logic [NPADS-1:0] liveOut;
  logic [NPADS-1:0] liveOe;
  logic [NPADS-1:0][DRV_W-1:0] liveDrive;
  logic [NPADS-1:0] livePullUp;
  logic [NPADS-1:0] livePullDown;
  logic [NPADS-1:0][HOLD_W-1:0] liveVec;
  logic [NPADS-1:0][HOLD_W-1:0] heldVec;

  // Core-domain control: route bits, strap, deep-sleep keep and wake
  always_comb
  begin
    next_route = padRouteToMainMux;
    if (routeWrEn)
    begin
      next_route = routeWrData; // see R2
    end
    next_strapState = strapState;
    next_strapSel = strapSel;
    // Strap is caught on the first edge after release, never by the reset
    if (strapState == STRAP_WAIT)
    begin
      next_strapSel = voltageStrapPad; // see R11
      next_strapState = STRAP_DONE;
    end
    // Fuse picks the default, software wins over both
    if (swVoltOverride)
    begin
      next_volt = swVoltSel1v8; // see R12
    end
    else if (fuseVoltForce)
    begin
      next_volt = fuseVoltSel1v8; // see R12
    end
    else
    begin
      next_volt = next_strapSel ? VSEL_1V8 : VSEL_LP_DOMAIN; // see R11
    end
    // Output level frozen at deep-sleep entry, tracked otherwise
    next_keepOut = deepSleep ? keepOut : lpOut; // see R14
    next_keepOe = deepSleep ? keepOe : lpOe; // see R14
    next_wake = {NLP{deepSleep}} & ~padRouteToMainMux & lpWakeEn & lpIn; // see R14
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      padRouteToMainMux <= {NLP{ROUTE_MAIN_RESET}}; // see R1
      strapState <= STRAP_WAIT;
      strapSel <= 1'b0;
      sdioVolt1v8 <= VSEL_LP_DOMAIN;
      keepOut <= '0;
      keepOe <= '0;
      lpWakeReq <= '0;
    end
    else
    begin
      padRouteToMainMux <= next_route;
      strapState <= next_strapState;
      strapSel <= next_strapSel;
      sdioVolt1v8 <= next_volt;
      keepOut <= next_keepOut;
      keepOe <= next_keepOe;
      lpWakeReq <= next_wake;
    end
  end

  // Hold enables live in the low-power domain: power-on reset only
  always_comb
  begin
    next_hold = holdEnable;
    if (holdWrEn)
    begin
      next_hold = holdWrData; // see R8
    end
  end

  always_ff @(posedge clk)
  begin
    if (!npor)
    begin
      holdEnable <= {NPADS{HOLD_RESET}};
    end
    else
    begin
      holdEnable <= next_hold; // see R10
    end
  end

  assign lpOutEff = deepSleep ? keepOut : lpOut;
  assign lpOeEff = deepSleep ? keepOe : lpOe;
  assign lpAnalogEn = ~padRouteToMainMux; // see R3

  // Pad-side selection; purely combinational so set changes take effect at once
  always_comb
  begin
    lpRouted = '0;
    lpIn = '0;
    for (int p = 0; p < NPADS; p++)
    begin
      useSleep[p] = sleepSetSelect[p] & lightSleep; // see R15
      if (useSleep[p])
      begin
        liveOe[p] = sleepOutputEnable[p]; // see R6
        liveDrive[p] = sleepDriveStrength[p]; // see R5
        livePullUp[p] = sleepPullUp[p]; // see R6
        livePullDown[p] = sleepPullDown[p]; // see R6
      end
      else
      begin
        liveOe[p] = matrixOutputEnableSel[p]; // see R7
        liveDrive[p] = normalDriveStrength[p]; // see R7
        livePullUp[p] = normalPullUp[p];
        livePullDown[p] = normalPullDown[p];
      end
      liveOut[p] = muxOut[p];
    end
    for (int l = 0; l < NLP; l++)
    begin
      if (!padRouteToMainMux[l])
      begin
        lpRouted[LP_PAD_MAP[l]] = 1'b1; // see R4
        lpIn[l] = padIn[LP_PAD_MAP[l]]; // see R2
        liveOut[LP_PAD_MAP[l]] = lpOutEff[l]; // see R3
        liveOe[LP_PAD_MAP[l]] = lpOeEff[l]; // see R3
        liveDrive[LP_PAD_MAP[l]] = lpDrive[l];
        livePullUp[LP_PAD_MAP[l]] = lpPullUp[l];
        livePullDown[LP_PAD_MAP[l]] = lpPullDown[l];
      end
    end
    // Main mux sees a quiet zero from pads handed to the low-power side
    mainIn = padIn & ~lpRouted; // see R2
    for (int p = 0; p < NPADS; p++)
    begin
      liveVec[p] = {liveOut[p], liveOe[p], liveDrive[p], livePullUp[p], livePullDown[p]};
      {padOut[p], padOe[p], padDrive[p], padPullUp[p], padPullDown[p]} = heldVec[p];
    end
  end

  // One hold cell per pad, independent of routing and resets of the core
  for (genvar p = 0; p < NPADS; p++)
  begin : g_hold
    pad_hold_cell #(
      .W(HOLD_W)
    ) u_hold (
      .clk(clk),
      .npor(npor),
      .holdEn(holdEnable[p]),
      .live(liveVec[p]),
      .out(heldVec[p]),
      .held(padHeld[p])
    ); // see R9
  end

  sig_index_info u_sig (
    .clk(clk),
    .nrst(nrst),
    .sigIndex(sigIndex),
    .sigHasInput(sigHasInput),
    .sigHasOutput(sigHasOutput),
    .sigDirectBypass(sigDirectBypass)
  ); // see R13

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Checks watch low-power pin 0 and the last pad as representatives
  localparam int LP0 = int'(LP_PAD_MAP[0]);
  localparam int TOP = NPADS - 1;

  sequence s_strap_taken;
    strapState == STRAP_WAIT ##1 strapState == STRAP_DONE;
  endsequence

  a_route_reset: assert property ($rose(nrst) |-> padRouteToMainMux == {NLP{1'b1}}) // see R1
    else $error("Route bits not at main mux after reset");
  a_lp_route_in: assert property (!padRouteToMainMux[0] |-> !mainIn[LP0]
    && lpIn[0] == padIn[LP0] && lpAnalogEn[0]) // see R2
    else $error("Low-power pad input not redirected");
  a_lp_route_out: assert property (!padRouteToMainMux[0] && !deepSleep
    && !padHeld[LP0] && !holdEnable[LP0] |-> padOut[LP0] == lpOut[0]
    && padOe[LP0] == lpOe[0]) // see R3
    else $error("Low-power pad output not from pin control");
  a_sleep_set: assert property (lightSleep && sleepSetSelect[TOP] && !lpRouted[TOP]
    && !holdEnable[TOP] && !padHeld[TOP] |-> padDrive[TOP] == sleepDriveStrength[TOP]
    && padOe[TOP] == sleepOutputEnable[TOP] && padPullUp[TOP] == sleepPullUp[TOP]) // see R6
    else $error("Sleep control set not applied");
  a_normal_set: assert property (!(lightSleep && sleepSetSelect[TOP]) && !lpRouted[TOP]
    && !holdEnable[TOP] && !padHeld[TOP] |-> padOe[TOP] == matrixOutputEnableSel[TOP]
    && padDrive[TOP] == normalDriveStrength[TOP]) // see R7
    else $error("Normal control set not applied");
  a_strap_latch: assert property (s_strap_taken ##0 !swVoltOverride && !fuseVoltForce
    |-> sdioVolt1v8 == $past(voltageStrapPad)) // see R11
    else $error("Strap level not reflected in supply select");
  a_sw_override: assert property (swVoltOverride |=> sdioVolt1v8 == $past(swVoltSel1v8)) // see R12
    else $error("Software supply override ignored");
  a_deep_keep: assert property (deepSleep && $past(deepSleep) && !padRouteToMainMux[0]
    && !holdEnable[LP0] && !padHeld[LP0] |-> padOut[LP0] == $past(padOut[LP0])) // see R14
    else $error("Low-power pad output moved in deep sleep");
  a_deep_wake: assert property (deepSleep && !padRouteToMainMux[0] && lpWakeEn[0]
    && padIn[LP0] |=> lpWakeReq[0]) // see R14
    else $error("Deep-sleep wake request missing");
  a_wake_quiet: assert property (!deepSleep |=> lpWakeReq == '0) // see R14
    else $error("Wake request outside deep sleep");
  a_lp_route_ctl: assert property (!padRouteToMainMux[0] && !padHeld[LP0] && !holdEnable[LP0]
    |-> padDrive[LP0] == lpDrive[0] && padPullUp[LP0] == lpPullUp[0]
    && padPullDown[LP0] == lpPullDown[0]) // see R3
    else $error("Low-power pad drive or pulls not from pin control");
  a_main_default: assert property (padRouteToMainMux[0] |-> !lpIn[0] && !lpAnalogEn[0]
    && mainIn[LP0] == padIn[LP0]) // see R1
    else $error("Main-mux routed pad leaks to low-power side");
endmodule

// File: tb/pad_world_model.sv
`timescale 1ns/1ns
module pad_world_model
  import pad_lp_pkg::*;
(
  input wire logic [NUM_PADS-1:0] padOut,
  input wire logic [NUM_PADS-1:0] padOe,
  input wire logic [NUM_PADS-1:0] padPullUp,
  input wire logic [NUM_PADS-1:0] padPullDown,
  input wire logic [NUM_PADS-1:0] extLevel,
  output logic [NUM_PADS-1:0] padIn
);
  // Driven pad reads back its own level; a released pad follows its pull,
  // else the outside level, so a stale value never passes for a reading
  always_comb
  begin
    for (int i = 0; i < NUM_PADS; i++)
    begin
      if (padOe[i])
        padIn[i] = padOut[i];
      else if (padPullUp[i])
        padIn[i] = 1'b1;
      else if (padPullDown[i])
        padIn[i] = 1'b0;
      else
        padIn[i] = extLevel[i];
    end
  end
endmodule

// File: tb/pad_lowpower_route_hold_bench.sv
`timescale 1ns/1ns
module pad_lowpower_route_hold_bench
  import pad_lp_pkg::*;
;
  logic clk, nrst, npor, routeWrEn, lightSleep, deepSleep, holdWrEn;
  logic voltageStrapPad, fuseVoltForce, fuseVoltSel1v8, swVoltOverride, swVoltSel1v8;
  logic [NUM_LP_PINS-1:0] routeWrData, padRouteToMainMux, lpOut, lpOe, lpPullUp;
  logic [NUM_LP_PINS-1:0] lpPullDown, lpWakeEn, lpIn, lpAnalogEn, lpWakeReq;
  logic [NUM_LP_PINS-1:0][DRV_W-1:0] lpDrive;
  logic [NUM_PADS-1:0] muxOut, matrixOutputEnableSel, normalPullUp, normalPullDown;
  logic [NUM_PADS-1:0] sleepSetSelect, sleepPullUp, sleepPullDown, sleepOutputEnable;
  logic [NUM_PADS-1:0] mainIn, holdWrData, holdEnable, padIn, padOut, padOe, extLevel;
  logic [NUM_PADS-1:0] padPullUp, padPullDown, padHeld;
  logic [NUM_PADS-1:0][DRV_W-1:0] normalDriveStrength, sleepDriveStrength, padDrive;
  logic sdioVolt1v8, sigHasInput, sigHasOutput, sigDirectBypass;
  logic [SIG_IDX_W-1:0] sigIndex;
  logic [7:0] sigIdx [8] = '{8'h00, 8'h06, 8'h13, 8'h25, 8'h27, 8'h3F, 8'h7A, 8'hE0};
  logic [2:0] sigExp [8] = '{3'h7, 3'h6, 3'h0, 3'h2, 3'h4, 3'h7, 3'h4, 3'h2};
  int miscompares, checkCount;

  pad_lowpower_route_hold #(.NPADS(NUM_PADS), .NLP(NUM_LP_PINS)) u_pad_lowpower_route_hold (
    .clk, .nrst, .npor, .routeWrEn, .routeWrData, .padRouteToMainMux,
    .muxOut, .matrixOutputEnableSel, .normalDriveStrength, .normalPullUp, .normalPullDown,
    .sleepSetSelect, .sleepDriveStrength, .sleepPullUp, .sleepPullDown, .sleepOutputEnable,
    .mainIn, .lpOut, .lpOe, .lpDrive, .lpPullUp, .lpPullDown, .lpWakeEn, .lpIn,
    .lpAnalogEn, .lpWakeReq, .lightSleep, .deepSleep, .holdWrEn, .holdWrData, .holdEnable,
    .padIn, .padOut, .padOe, .padDrive, .padPullUp, .padPullDown, .padHeld,
    .voltageStrapPad, .fuseVoltForce, .fuseVoltSel1v8, .swVoltOverride, .swVoltSel1v8,
    .sdioVolt1v8, .sigIndex, .sigHasInput, .sigHasOutput, .sigDirectBypass);

  pad_world_model u_pad_world_model (
    .padOut, .padOe, .padPullUp, .padPullDown, .extLevel, .padIn);

  always #10 clk = ~clk;

  task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
    checkCount++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run is some 57 cycles; the margin covers a stuck sequence only
  initial
  begin
    #40000;
    miscompares++;
    end_of_test();
  end

  initial
  begin
    {clk, nrst, npor, routeWrEn, lightSleep, deepSleep, holdWrEn} = '0;
    {voltageStrapPad, fuseVoltForce, fuseVoltSel1v8, swVoltOverride, swVoltSel1v8} = '0;
    {routeWrData, lpOut, lpOe, lpPullUp, lpPullDown, lpWakeEn, lpDrive} = '0;
    {muxOut, matrixOutputEnableSel, normalPullUp, normalPullDown, sleepSetSelect} = '0;
    {sleepPullUp, sleepPullDown, sleepOutputEnable, holdWrData, extLevel} = '0;
    {normalDriveStrength, sleepDriveStrength, sigIndex} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    npor <= 1'b1;
    @(posedge clk);
    #1;
    chk("route", 34'h3FFFF, padRouteToMainMux);
    chk("volt", VSEL_LP_DOMAIN, sdioVolt1v8);
    // Low-power side takes pads 0 and 5
    @(posedge clk);
    routeWrEn <= 1'b1;
    routeWrData <= 18'h3FFDE;
    lpOut[0] <= 1'b1;
    lpOe[0] <= 1'b1;
    lpPullUp[5] <= 1'b1;
    lpWakeEn[5] <= 1'b1;
    lpWakeEn[0] <= 1'b1;
    @(posedge clk);
    routeWrEn <= 1'b0;
    #1;
    chk("route", 34'h3FFDE, padRouteToMainMux);
    chk("analog", 34'h00021, lpAnalogEn);
    chk("mainIn0", 1'b0, mainIn[0]);
    chk("padOe0", 1'b1, padOe[0]);
    chk("lpIn", 34'h00021, lpIn);
    @(posedge clk);
    deepSleep <= 1'b1;
    @(posedge clk);
    lpOut[0] <= 1'b0;
    lpOe[0] <= 1'b0;
    #1;
    chk("padOut0", 1'b1, padOut[0]);
    chk("padOe0", 1'b1, padOe[0]);
    chk("wake", 34'h00021, lpWakeReq);
    // Control sets on pads 32 and 33
    @(posedge clk);
    deepSleep <= 1'b0;
    lightSleep <= 1'b1;
    sleepSetSelect[33] <= 1'b1;
    normalDriveStrength[33] <= 2'h1;
    sleepDriveStrength[33] <= 2'h2;
    sleepOutputEnable[33] <= 1'b1;
    sleepPullUp[33] <= 1'b1;
    normalDriveStrength[32] <= 2'h3;
    normalPullDown[32] <= 1'b1;
    sleepPullDown[33] <= 1'b1;
    #1;
    chk("pd32", 1'b1, padPullDown[32]);
    chk("pd33", 1'b1, padPullDown[33]);
    chk("drv33", 2'h2, padDrive[33]);
    chk("oe33", 1'b1, padOe[33]);
    chk("pu33", 1'b1, padPullUp[33]);
    chk("drv32", 2'h3, padDrive[32]);
    @(posedge clk);
    lightSleep <= 1'b0;
    #1;
    chk("drv33", 2'h1, padDrive[33]);
    chk("oe33", 1'b0, padOe[33]);
    chk("pd33", 1'b0, padPullDown[33]);
    // Hold on pad 3, then disturb it and reset the core
    @(posedge clk);
    muxOut[3] <= 1'b1;
    matrixOutputEnableSel[3] <= 1'b1;
    holdWrEn <= 1'b1;
    holdWrData <= 34'h8;
    @(posedge clk);
    holdWrEn <= 1'b0;
    @(posedge clk);
    muxOut[3] <= 1'b0;
    matrixOutputEnableSel[3] <= 1'b0;
    #1;
    chk("holdEn", 34'h8, holdEnable);
    chk("padOut3", 1'b1, padOut[3]);
    chk("padOe3", 1'b1, padOe[3]);
    @(posedge clk);
    nrst <= 1'b0;
    voltageStrapPad <= 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk("padOut3", 1'b1, padOut[3]);
    chk("held", 34'h8, padHeld);
    chk("volt", VSEL_1V8, sdioVolt1v8);
    @(posedge clk);
    fuseVoltForce <= 1'b1;
    @(posedge clk);
    #1;
    chk("volt", 1'b0, sdioVolt1v8);
    @(posedge clk);
    swVoltOverride <= 1'b1;
    swVoltSel1v8 <= 1'b1;
    @(posedge clk);
    #1;
    chk("volt", 1'b1, sdioVolt1v8);
    @(posedge clk);
    holdWrEn <= 1'b1;
    holdWrData <= '0;
    @(posedge clk);
    holdWrEn <= 1'b0;
    @(posedge clk);
    #1;
    chk("padOut3", 1'b0, padOut[3]);
    chk("held", 34'h0, padHeld);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      sigIndex <= sigIdx[i];
      @(posedge clk);
      #1;
      chk("sig", sigExp[i], {sigHasInput, sigHasOutput, sigDirectBypass});
    end
    end_of_test();
  end
endmodule
